// ==== core/aiof_pkg.sv ====
// Constants, types and scaling helpers for the accelerometer and inclinometer output formatter.
package aiof_pkg;

  localparam int WORD_W      = 24;
  localparam int BYTE_W      = 8;
  localparam int WORD_BYTES  = WORD_W / BYTE_W;
  localparam int NCH         = 6;
  localparam int NACC        = 3;
  localparam int SAMPLE_W    = 32;
  localparam int SAMPLE_FRAC = 24;
  localparam int CNT_W       = 16;
  localparam int SUM_W       = SAMPLE_W + CNT_W;
  localparam int VINT_W      = 64;
  localparam int SHIFT_W     = 6;

  // Velocity change per sample for 1 g, in m/s, unsigned with K_FRAC fraction bits.
  // 9.80665 m/s2 times 0.5 ms, rounded to nearest.
  localparam int               K_W       = 26;
  localparam int               K_FRAC    = 32;
  localparam logic [K_W-1:0]   DV_PER_G  = 26'h1415825;
  localparam int               DV_W      = SAMPLE_W + K_W + 1;
  localparam logic [SHIFT_W-1:0] DV_FRAC = 6'(SAMPLE_FRAC + K_FRAC);

  // Fraction bits of the 24-bit word per range and unit.
  localparam logic [SHIFT_W-1:0] ACC_FRAC_5G   = 6'h14;
  localparam logic [SHIFT_W-1:0] ACC_FRAC_10G  = 6'h13;
  localparam logic [SHIFT_W-1:0] ACC_FRAC_30G  = 6'h12;
  localparam logic [SHIFT_W-1:0] ACC_FRAC_80G  = 6'h10;
  localparam logic [SHIFT_W-1:0] VEL_FRAC_5G   = 6'h17;
  localparam logic [SHIFT_W-1:0] VEL_FRAC_10G  = 6'h16;
  localparam logic [SHIFT_W-1:0] VEL_FRAC_30G  = 6'h15;
  localparam logic [SHIFT_W-1:0] VEL_FRAC_80G  = 6'h13;
  localparam logic [SHIFT_W-1:0] INCL_ACC_FRAC = 6'h16;
  localparam logic [SHIFT_W-1:0] INCL_VEL_FRAC = 6'h19;

  localparam logic [WORD_W-1:0] WORD_MAX = 24'h7FFFFF;
  localparam logic [WORD_W-1:0] WORD_MIN = 24'h800000;

  // Internal sample period and the clock period, in ns.
  localparam int CLK_PERIOD_NS    = 100;
  localparam int SAMPLE_PERIOD_NS = 500000;
  localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    RNG_5G  = 2'b00,
    RNG_10G = 2'b01,
    RNG_30G = 2'b10,
    RNG_80G = 2'b11
  } aiof_range_t;

  typedef enum logic [1:0] {
    UNIT_ACC  = 2'b00,
    UNIT_VINC = 2'b01,
    UNIT_AVG  = 2'b10,
    UNIT_VINT = 2'b11
  } aiof_unit_t;

  function automatic logic [SHIFT_W-1:0] acc_frac(input aiof_range_t r, input logic incl);
    logic [SHIFT_W-1:0] f;
    f = ACC_FRAC_5G;
    case (r)
      RNG_5G:  f = ACC_FRAC_5G;
      RNG_10G: f = ACC_FRAC_10G;
      RNG_30G: f = ACC_FRAC_30G;
      RNG_80G: f = ACC_FRAC_80G;
    endcase
    return incl ? INCL_ACC_FRAC : f;
  endfunction

  function automatic logic [SHIFT_W-1:0] vel_frac(input aiof_range_t r, input logic incl);
    logic [SHIFT_W-1:0] f;
    f = VEL_FRAC_5G;
    case (r)
      RNG_5G:  f = VEL_FRAC_5G;
      RNG_10G: f = VEL_FRAC_10G;
      RNG_30G: f = VEL_FRAC_30G;
      RNG_80G: f = VEL_FRAC_80G;
    endcase
    return incl ? INCL_VEL_FRAC : f;
  endfunction

  function automatic logic [WORD_W-1:0] sat_word(input logic signed [VINT_W-1:0] v);
    logic [WORD_W-1:0] w;
    w = v[WORD_W-1:0];
    if (v > $signed(VINT_W'(WORD_MAX))) w = WORD_MAX;
    if (v < -$signed(VINT_W'(WORD_MAX)) - 1) w = WORD_MIN;
    return w;
  endfunction

endpackage

// ==== core/aiof_ser_if.sv ====
// Carrier between the formatter core and its byte serializer.
`timescale 1ns/1ps
interface aiof_ser_if;
  logic                                            load;
  logic [aiof_pkg::NCH*aiof_pkg::WORD_W-1:0]       words;
  logic [aiof_pkg::BYTE_W-1:0]                     byte_data;
  logic                                            byte_valid;
  logic                                            byte_last;
  logic                                            byte_ready;
  logic                                            busy;

  modport core (output load, output words, output byte_ready,
                input byte_data, input byte_valid, input byte_last, input busy);
  modport ser  (input load, input words, input byte_ready,
                output byte_data, output byte_valid, output byte_last, output busy);
endinterface

// ==== core/aiof_serializer.sv ====
// Byte serializer that sends the latched channel words, most significant byte first.
`timescale 1ns/1ps
module aiof_serializer (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  aiof_ser_if.ser   sif
);
  localparam int NBYTES = aiof_pkg::NCH * aiof_pkg::WORD_BYTES;
  localparam int BCNT_W = $clog2(NBYTES + 1);
  localparam int SH_W   = aiof_pkg::NCH * aiof_pkg::WORD_W;

  logic [SH_W-1:0]   shreg_q;
  logic [BCNT_W-1:0] left_q;

  // Channel 0 sits in the top bits, so it leaves first, high byte before low.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shreg_q <= '0;
    end else if (sif.load) begin
      shreg_q <= sif.words;
    end else if (sif.byte_valid && sif.byte_ready) begin
      shreg_q <= {shreg_q[SH_W-aiof_pkg::BYTE_W-1:0], {aiof_pkg::BYTE_W{1'b0}}};
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left_q <= '0;
    end else if (sif.load) begin
      left_q <= BCNT_W'(NBYTES);
    end else if (sif.byte_valid && sif.byte_ready) begin
      left_q <= left_q - BCNT_W'(1);
    end
  end

  assign sif.byte_data  = shreg_q[SH_W-1 -: aiof_pkg::BYTE_W];
  assign sif.busy       = (left_q != '0);
  assign sif.byte_valid = sif.busy;
  assign sif.byte_last  = (left_q == BCNT_W'(1));
endmodule

// ==== core/aiof_top.sv ====
// Accelerometer and inclinometer output formatter: scaling, averaging, integration, bytes.
`timescale 1ns/1ps
module aiof_top #(
  parameter int SAMPLE_CYCLES = aiof_pkg::SAMPLE_CYCLES
) (
  input  wire logic                                      clk_sys_i,
  input  wire logic                                      rst_n_i,
  input  wire aiof_pkg::aiof_range_t                     range_i,
  input  wire aiof_pkg::aiof_unit_t [aiof_pkg::NCH-1:0]  unit_i,
  input  wire logic [aiof_pkg::NCH-1:0][aiof_pkg::SAMPLE_W-1:0] sample_i,
  output logic                                           sample_tick_o,
  input  wire logic                                      tx_i,
  output logic                                           tx_ready_o,
  output logic [aiof_pkg::NCH-1:0][aiof_pkg::WORD_W-1:0] word_o,
  output logic                                           word_valid_o,
  output logic [aiof_pkg::BYTE_W-1:0]                    byte_o,
  output logic                                           byte_valid_o,
  output logic                                           byte_last_o,
  input  wire logic                                      byte_ready_i
);
  localparam int TICK_W = $clog2(SAMPLE_CYCLES);

  aiof_ser_if sif ();

  logic [TICK_W-1:0] tick_cnt_q;
  logic              tick_q;
  logic              load_q;
  logic              tx_take;

  // Sample rate divider; runs free from reset, regardless of transmissions.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_q <= '0;
    end else if (tick_cnt_q == TICK_W'(SAMPLE_CYCLES - 1)) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TICK_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_W'(SAMPLE_CYCLES - 1));
    end
  end

  // A transmit is refused while the previous set of words is still being sent.
  assign tx_ready_o = !sif.busy && !load_q;
  assign tx_take    = tx_i && tx_ready_o;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      load_q <= 1'b0;
    end else begin
      load_q <= tx_take;
    end
  end

  genvar i;
  generate
    for (i = 0; i < aiof_pkg::NCH; i++) begin : g_ch
      localparam logic INCL = (i >= aiof_pkg::NACC);

      logic signed [aiof_pkg::SAMPLE_W-1:0] x;
      logic signed [aiof_pkg::DV_W-1:0]     dv;
      logic signed [aiof_pkg::SAMPLE_W-1:0] last_x_q;
      logic signed [aiof_pkg::DV_W-1:0]     last_dv_q;
      logic signed [aiof_pkg::SUM_W-1:0]    sum_q;
      logic [aiof_pkg::CNT_W-1:0]           cnt_q;
      logic signed [aiof_pkg::VINT_W-1:0]   vint_q;
      logic [aiof_pkg::WORD_W-1:0]          word_q;
      logic [aiof_pkg::WORD_W-1:0]          word_d;
      logic [aiof_pkg::SHIFT_W-1:0]         acc_sh;
      logic [aiof_pkg::SHIFT_W-1:0]         vel_sh;
      logic signed [aiof_pkg::SUM_W-1:0]    avg;
      logic signed [aiof_pkg::VINT_W-1:0]   vint_sh;

      assign x  = sample_i[i];
      // Velocity change over one sample period, LSB 2^-56 m/s.
      assign dv = x * $signed({1'b0, aiof_pkg::DV_PER_G});

      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          last_x_q  <= '0;
          last_dv_q <= '0;
        end else if (tick_q) begin
          last_x_q  <= x;
          last_dv_q <= dv;
        end
      end

      // A sample in the transmit cycle opens the new interval; the count saturates.
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          sum_q <= '0;
          cnt_q <= '0;
        end else if (tx_take) begin
          sum_q <= tick_q ? aiof_pkg::SUM_W'(x) : '0;
          cnt_q <= tick_q ? aiof_pkg::CNT_W'(1) : '0;
        end else if (tick_q && (cnt_q != '1)) begin
          sum_q <= sum_q + aiof_pkg::SUM_W'(x);
          cnt_q <= cnt_q + aiof_pkg::CNT_W'(1);
        end
      end

      // Free-running integral from reset; the wide register wraps with no flag.
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          vint_q <= '0;
        end else if (tick_q) begin
          vint_q <= vint_q + aiof_pkg::VINT_W'(dv);
        end
      end

      always_comb begin
        acc_sh  = aiof_pkg::SHIFT_W'(aiof_pkg::SAMPLE_FRAC)
                  - aiof_pkg::acc_frac(range_i, INCL);
        vel_sh  = aiof_pkg::DV_FRAC - aiof_pkg::vel_frac(range_i, INCL);
        avg     = (cnt_q == '0) ? aiof_pkg::SUM_W'(last_x_q)
                  : sum_q / $signed({1'b0, cnt_q});
        vint_sh = vint_q >>> vel_sh;
        word_d  = word_q;
        unique case (unit_i[i])
          aiof_pkg::UNIT_ACC:
            word_d = aiof_pkg::sat_word(aiof_pkg::VINT_W'(last_x_q >>> acc_sh));
          aiof_pkg::UNIT_VINC:
            word_d = aiof_pkg::sat_word(aiof_pkg::VINT_W'(last_dv_q >>> vel_sh));
          aiof_pkg::UNIT_AVG:
            word_d = aiof_pkg::sat_word(aiof_pkg::VINT_W'(avg >>> acc_sh));
          aiof_pkg::UNIT_VINT:
            word_d = vint_sh[aiof_pkg::WORD_W-1:0];
        endcase
      end

      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          word_q <= '0;
        end else if (tx_take) begin
          word_q <= word_d;
        end
      end

      assign word_o[i] = word_q;
      assign sif.words[(aiof_pkg::NCH-1-i)*aiof_pkg::WORD_W +: aiof_pkg::WORD_W] = word_q;
    end
  endgenerate

  assign sif.load       = load_q;
  assign sif.byte_ready = byte_ready_i;

  aiof_serializer u_ser (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .sif       (sif)
  );

  assign sample_tick_o = tick_q;
  assign word_valid_o  = load_q;
  assign byte_o        = sif.byte_data;
  assign byte_valid_o  = sif.byte_valid;
  assign byte_last_o   = sif.byte_last;
endmodule

// ==== testbench/aiof_top_sva.sv ====
// Timing checker for the output formatter ports.
`timescale 1ns/1ps
module aiof_top_sva #(
  parameter int SAMPLE_CYCLES = aiof_pkg::SAMPLE_CYCLES
) (
  input wire logic                                           clk_sys_i,
  input wire logic                                           rst_n_i,
  input wire logic                                           sample_tick_o,
  input wire logic                                           tx_i,
  input wire logic                                           tx_ready_o,
  input wire logic [aiof_pkg::NCH-1:0][aiof_pkg::WORD_W-1:0] word_o,
  input wire logic                                           word_valid_o,
  input wire logic [aiof_pkg::BYTE_W-1:0]                    byte_o,
  input wire logic                                           byte_valid_o,
  input wire logic                                           byte_last_o,
  input wire logic                                           byte_ready_i
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  int   tcnt;
  int   bcnt;
  logic seen_q;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tcnt <= 0;
      seen_q <= 1'b0;
    end else begin
      tcnt <= sample_tick_o ? 0 : tcnt + 1;
      seen_q <= seen_q | sample_tick_o;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bcnt <= 0;
    end else if (word_valid_o) begin
      bcnt <= 0;
    end else if (byte_valid_o && byte_ready_i) begin
      bcnt <= bcnt + 1;
    end
  end
  property p_tick; sample_tick_o && seen_q |-> tcnt == SAMPLE_CYCLES - 1; endproperty
  a_tick: assert property (p_tick) else $error("sample tick spacing wrong");
  property p_accept; tx_i && tx_ready_o |=> word_valid_o ##1 !word_valid_o; endproperty
  a_accept: assert property (p_accept) else $error("word valid not one cycle after accept");
  property p_hold; !word_valid_o |-> $stable(word_o); endproperty
  a_hold: assert property (p_hold) else $error("words changed without a transmit");
  property p_first; word_valid_o |=> byte_valid_o && byte_o == word_o[0][23:16]; endproperty
  a_first: assert property (p_first) else $error("first byte is not channel 0 high byte");
  property p_stall; byte_valid_o && !byte_ready_i |=> byte_valid_o && $stable(byte_o); endproperty
  a_stall: assert property (p_stall) else $error("byte dropped while sink stalled");
  property p_last; byte_valid_o && byte_last_o |-> bcnt == 17; endproperty
  a_last: assert property (p_last) else $error("last byte not the eighteenth");
  property p_end; byte_valid_o && byte_last_o && byte_ready_i |=> !byte_valid_o && tx_ready_o; endproperty
  a_end: assert property (p_end) else $error("stream did not end after last byte");
  property p_busy; byte_valid_o || word_valid_o |-> !tx_ready_o; endproperty
  a_busy: assert property (p_busy) else $error("transmit accepted while bytes remain");
endmodule
bind aiof_top aiof_top_sva #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) u_sva (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sample_tick_o(sample_tick_o), .tx_i(tx_i),
  .tx_ready_o(tx_ready_o), .word_o(word_o), .word_valid_o(word_valid_o), .byte_o(byte_o),
  .byte_valid_o(byte_valid_o), .byte_last_o(byte_last_o), .byte_ready_i(byte_ready_i));

// ==== testbench/aiof_byte_sink.sv ====
// Host side byte receiver that can stall between bytes.
`timescale 1ns/1ps
module aiof_byte_sink (
  input  wire logic       clk_sys_i,
  input  wire logic [7:0] byte_i,
  input  wire logic       valid_i,
  input  wire logic       last_i,
  input  wire logic       stall_i,
  output logic            ready_o
);
  logic [7:0] q[$];
  int         last_pos = -1;
  int         ph = 0;
  initial ready_o = 1'b0;
  always @(negedge clk_sys_i) begin
    ph <= ph + 1;
    ready_o <= !stall_i || (ph % 3 == 0);
  end
  always @(posedge clk_sys_i) begin
    if (valid_i && ready_o) begin
      if (last_i) last_pos = q.size();
      q.push_back(byte_i);
    end
  end
endmodule

// ==== testbench/aiof_top_bench.sv ====
// Self-checking bench with a reference model of the formatter.
`timescale 1ns/1ps
module aiof_top_bench;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  aiof_pkg::aiof_range_t range_i = aiof_pkg::RNG_5G;
  aiof_pkg::aiof_unit_t [5:0] unit_i = '{6{aiof_pkg::UNIT_ACC}};
  logic [5:0][31:0] sample_i = '0;
  logic [31:0] base[6] = '{default: 0};
  logic [31:0] step[6] = '{default: 0};
  logic tx_i = 1'b0;
  logic stall = 1'b0;
  logic sample_tick_o, tx_ready_o, word_valid_o, byte_valid_o, byte_last_o, byte_ready_i;
  logic [5:0][23:0] word_o;
  logic [7:0] byte_o;
  logic signed [31:0] last[6];
  longint sum[6], integ[6];
  int cnt[6];
  int k;
  logic [23:0] expw[6];
  int err_total = 0;
  int total_checks = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  aiof_top #(.SAMPLE_CYCLES(8)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .range_i(range_i), .unit_i(unit_i), .sample_i(sample_i), .sample_tick_o(sample_tick_o),
    .tx_i(tx_i), .tx_ready_o(tx_ready_o), .word_o(word_o), .word_valid_o(word_valid_o),
    .byte_o(byte_o), .byte_valid_o(byte_valid_o), .byte_last_o(byte_last_o),
    .byte_ready_i(byte_ready_i));
  aiof_byte_sink sink (.clk_sys_i(clk_sys_i), .byte_i(byte_o), .valid_i(byte_valid_o),
    .last_i(byte_last_o), .stall_i(stall), .ready_o(byte_ready_i));
  always @(negedge clk_sys_i) begin
    for (int c = 0; c < 6; c++) sample_i[c] <= base[c] + step[c] * k;
  end
  function automatic logic [23:0] ew(int c);
    int fa, fv;
    longint v;
    fa = (c >= 3) ? 22 : ((range_i == 0) ? 20 : (range_i == 1) ? 19 : (range_i == 2) ? 18 : 16);
    fv = (c >= 3) ? 25 : ((range_i == 0) ? 23 : (range_i == 1) ? 22 : (range_i == 2) ? 21 : 19);
    case (unit_i[c])
      aiof_pkg::UNIT_ACC:  v = longint'(last[c]) >>> (24 - fa);
      aiof_pkg::UNIT_AVG:  v = ((cnt[c] == 0) ? longint'(last[c]) : sum[c] / cnt[c]) >>> (24 - fa);
      aiof_pkg::UNIT_VINC: v = (longint'(last[c]) * longint'(aiof_pkg::DV_PER_G)) >>> (56 - fv);
      default: return 24'(integ[c] >>> (56 - fv));
    endcase
    if (v > 64'sd8388607) return 24'h7FFFFF;
    if (v < -64'sd8388608) return 24'h800000;
    return v[23:0];
  endfunction
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      k = 0;
      for (int c = 0; c < 6; c++) begin
        last[c] = 0; sum[c] = 0; cnt[c] = 0; integ[c] = 0;
      end
    end else begin
      if (tx_i && tx_ready_o) begin
        for (int c = 0; c < 6; c++) begin
          expw[c] = ew(c); sum[c] = 0; cnt[c] = 0;
        end
      end
      if (sample_tick_o) begin
        k++;
        for (int c = 0; c < 6; c++) begin
          last[c] = sample_i[c];
          sum[c] += longint'(last[c]);
          cnt[c]++;
          integ[c] += longint'(last[c]) * longint'(aiof_pkg::DV_PER_G);
        end
      end
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic setup(input logic [1:0] r, input logic [1:0] u);
    range_i = aiof_pkg::aiof_range_t'(r);
    for (int c = 0; c < 6; c++) unit_i[c] = aiof_pkg::aiof_unit_t'(u);
    rst_n_i = 1'b0;
    repeat (16) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
  endtask
  task automatic xfer(input logic st, input int gap);
    int n;
    stall = st;
    sink.q.delete();
    repeat (gap) @(negedge clk_sys_i);
    tx_i = 1'b1;
    n = 0;
    do begin @(negedge clk_sys_i); n++; end while (word_valid_o !== 1'b1 && n < 200);
    tx_i = 1'b0;
    if (n >= 200) begin
      err_total++;
      return;
    end
    for (int c = 0; c < 6; c++) check("word", word_o[c], expw[c]);
    n = 0;
    while (sink.q.size() < 18 && n < 400) begin @(negedge clk_sys_i); n++; end
    if (n >= 400) begin
      err_total++;
      return;
    end
    for (int b = 0; b < 18; b++) check("byte", sink.q[b], expw[b/3][23-8*(b%3) -: 8]);
    check("last", sink.last_pos, 17);
  endtask
  task automatic t_acc();
    base = '{32'h7FFFFFFF, 32'hFF012345, 32'h00ABCDEF, 32'h01800000, 32'hFE000001, 32'h00123456};
    step = '{default: 0};
    for (int r = 0; r < 4; r++) begin
      setup(r, aiof_pkg::UNIT_ACC);
      check("reset word", word_o[0], 0);
      xfer(1'b0, 12);
      unit_i = '{6{aiof_pkg::UNIT_VINC}};
      xfer(1'b0, 3);
    end
  endtask
  task automatic t_mix();
    base = '{32'h01000000, 32'hFF000000, 32'h00000007, 32'h00400000, 32'hFFC00000, 32'h00200000};
    step = '{32'h00010003, 32'hFFFFF001, 32'hFFFFFFFD, 32'h00000101, 32'h00100000, 32'hFFF00000};
    setup(2'b01, aiof_pkg::UNIT_AVG);
    unit_i[1] = aiof_pkg::UNIT_VINT;
    unit_i[4] = aiof_pkg::UNIT_VINT;
    unit_i[5] = aiof_pkg::UNIT_VINC;
    xfer(1'b0, 20);
    xfer(1'b0, 0);
    xfer(1'b1, 5);
  endtask
  task automatic t_wrap();
    base = '{32'h7FFFFFFF, 32'h80000000, 32'h40000000, 32'h7FFFFFFF, 32'h80000000, 32'h20000000};
    step = '{default: 0};
    for (int r = 0; r < 4; r += 3) begin
      setup(r, aiof_pkg::UNIT_VINT);
      for (int i = 0; i < 4; i++) xfer(i[0], 9);
    end
  endtask
  initial begin
    t_acc();
    t_mix();
    t_wrap();
    stop_test();
  end
endmodule
